//--- design/i2cid_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface i2cid_bus_if;
  logic scl;          // resolved clock line
  logic sda;          // resolved data line
  logic host_scl_oe;  // controller pulls clock low
  logic host_sda_oe;  // controller pulls data low
  logic dev_sda_oe;   // device pulls data low
  // open-drain wired-and with pull-ups
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport dev (input scl, input sda, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface
`default_nettype wire

//--- design/i2cid_dev.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module i2cid_dev #(
  parameter logic [i2cid_pkg::MAKER_W-1:0] MAKER_ID = 12'h5a3,  // arbitrary value
  parameter logic [i2cid_pkg::PART_W-1:0]  PART_ID  = 9'h0c6,   // arbitrary value
  parameter logic [i2cid_pkg::REV_W-1:0]   REV_ID   = 3'h1      // arbitrary value
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  i2cid_bus_if.dev        bus,
  input  wire logic       addr_strap_hi_i,
  input  wire logic       addr_strap_mid_i,
  input  wire logic       addr_strap_lo_i,
  output logic [7:0]      port_o,
  output logic [6:0]      own_addr_o,
  output logic            swrst_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} i2cid_dst_t;
  typedef enum logic [2:0] {CTX_NONE, CTX_GC, CTX_IDW, CTX_IDR, CTX_WR, CTX_RD} i2cid_ctx_t;

  localparam int ID_WORD_W = i2cid_pkg::ID_W; // identity word width

  logic [1:0]            scl_sync_ff;    // clock line synchroniser
  logic [1:0]            sda_sync_ff;    // data line synchroniser
  logic [2:0]            strap_s1_ff;    // straps, first stage
  logic [2:0]            strap_s2_ff;    // straps, second stage
  logic                  scl_prev_ff;    // last sampled clock
  logic                  sda_prev_ff;    // last sampled data
  logic [2:0]            neq_scl_ff;     // strap ever differed from clock
  logic [2:0]            neq_sda_ff;     // strap ever differed from data
  logic                  scl_low_ff;     // clock seen low since reset
  logic                  sda_low_ff;     // data seen low since reset
  i2cid_pkg::i2cid_strap_t strap_code [3]; // sensed strap states, lo..hi
  logic [6:0]            own_addr_ff;    // decoded slave address
  i2cid_dst_t            state_ff;       // bit-level state
  i2cid_ctx_t            ctx_ff;         // what this transfer is
  i2cid_ctx_t            nxt_ctx;        // context after an acknowledged byte
  logic [7:0]            shift_ff;       // receive or transmit shifter
  logic [3:0]            cnt_ff;         // bits moved in this byte
  logic                  first_ff;       // next byte is the address byte
  logic                  data_seen_ff;   // a data byte already taken
  logic                  rst_armed_ff;   // reset byte acknowledged
  logic                  id_sel_ff;      // selected for identity read
  logic [1:0]            id_idx_ff;      // identity byte index
  logic                  sda_oe_ff;      // pulls data low
  logic [7:0]            port_ff;        // port register
  logic                  swrst_ff;       // software reset pulse
  logic                  ack_c;          // acknowledge the byte just received
  logic                  scl_s;
  logic                  sda_s;
  logic                  start_det;
  logic                  stop_det;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  byte_done;
  logic                  swrst_c;
  logic [ID_WORD_W-1:0]  id_word;
  logic [7:0]            tx_byte;

  // identity is pure wiring, untouched by any reset
  assign id_word = {MAKER_ID, PART_ID, REV_ID};

  // map three sensed straps onto the slave address
  function automatic logic [6:0] addr_decode(input i2cid_pkg::i2cid_strap_t hi,
                                             input i2cid_pkg::i2cid_strap_t mid,
                                             input i2cid_pkg::i2cid_strap_t lo);
    logic [6:0] base;
    logic [6:0] step;
    case ({hi[1], mid[1]})
      2'b00:   base = i2cid_pkg::MAP_BASE_SS;
      2'b01:   base = i2cid_pkg::MAP_BASE_SB;
      2'b11:   base = i2cid_pkg::MAP_BASE_BB;
      default: base = i2cid_pkg::MAP_BASE_BS;
    endcase
    // only the upper-bus, middle-static combination spaces the lowest pin wider
    step = ({hi[1], mid[1]} == 2'b10) ? i2cid_pkg::MAP_LO_WIDE : i2cid_pkg::MAP_LO_STEP;
    return base | (lo[1] ? step : 7'h00) | {4'h0, hi[0], mid[0], lo[0]};
  endfunction

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      // idle-high like the bus lines, so a bus-tied pin gets no false disagreement
      strap_s1_ff <= 3'h7;
      strap_s2_ff <= 3'h7;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], bus.scl};
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
      strap_s1_ff <= {addr_strap_hi_i, addr_strap_mid_i, addr_strap_lo_i};
      strap_s2_ff <= strap_s1_ff;
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  assign scl_s     = scl_sync_ff[1];
  assign sda_s     = sda_sync_ff[1];
  assign start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_det  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign scl_rise  = scl_s & ~scl_prev_ff;
  assign scl_fall  = ~scl_s & scl_prev_ff;

  // a strap that never disagreed with a line that has moved follows that line;
  // until the bus has toggled the pin reads as static, a limitation at power-up
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      neq_scl_ff <= 3'h0;
      neq_sda_ff <= 3'h0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else begin
      neq_scl_ff <= neq_scl_ff | (strap_s2_ff ^ {3{scl_s}});
      neq_sda_ff <= neq_sda_ff | (strap_s2_ff ^ {3{sda_s}});
      scl_low_ff <= scl_low_ff | ~scl_s;
      sda_low_ff <= sda_low_ff | ~sda_s;
    end
  end

  // classify each pin into one of four states
  for (genvar i = 0; i < 3; i++) begin : g_strap
    always_comb begin
      if (!neq_scl_ff[i] && scl_low_ff) begin
        strap_code[i] = i2cid_pkg::STRAP_SCL;
      end else if (!neq_sda_ff[i] && sda_low_ff) begin
        strap_code[i] = i2cid_pkg::STRAP_SDA;
      end else begin
        strap_code[i] = strap_s2_ff[i] ? i2cid_pkg::STRAP_HIGH : i2cid_pkg::STRAP_LOW;
      end
    end
  end

  // decoded address, registered so compares see a clean value
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_addr_ff <= i2cid_pkg::MAP_BASE_SS;
    end else begin
      own_addr_ff <= addr_decode(strap_code[2], strap_code[1], strap_code[0]);
    end
  end

  assign byte_done = (state_ff == ST_RX) && scl_fall && (cnt_ff == i2cid_pkg::BYTE_BITS);

  // decide acknowledge and next context for the byte just shifted in
  always_comb begin
    ack_c   = 1'b0;
    nxt_ctx = CTX_NONE;
    if (first_ff) begin
      if (shift_ff == {i2cid_pkg::GC_ADDR, 1'b0}) begin
        ack_c   = 1'b1;
        nxt_ctx = CTX_GC;
      end else if (shift_ff[7:1] == i2cid_pkg::ID_ADDR) begin
        ack_c   = !shift_ff[0] || id_sel_ff;
        nxt_ctx = shift_ff[0] ? CTX_IDR : CTX_IDW;
      end else if (shift_ff[7:1] == own_addr_ff) begin
        ack_c   = 1'b1;
        nxt_ctx = shift_ff[0] ? CTX_RD : CTX_WR;
      end
    end else begin
      nxt_ctx = ctx_ff;
      case (ctx_ff)
        CTX_GC:  ack_c = !data_seen_ff && (shift_ff == i2cid_pkg::SWRST_BYTE);
        CTX_IDW: ack_c = !data_seen_ff && (shift_ff[7:1] == own_addr_ff);
        CTX_WR:  ack_c = 1'b1;
        default: ack_c = 1'b0;
      endcase
    end
  end

  // identity bytes leave in order, most significant first
  always_comb begin
    case (id_idx_ff)
      2'h0:    tx_byte = id_word[23:16];
      2'h1:    tx_byte = id_word[15:8];
      default: tx_byte = id_word[7:0];
    endcase
    if (ctx_ff == CTX_RD) begin
      tx_byte = port_ff;
    end
  end

  assign swrst_c = stop_det && rst_armed_ff;

  // bit-level slave engine
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff     <= ST_IDLE;
      ctx_ff       <= CTX_NONE;
      shift_ff     <= 8'h00;
      cnt_ff       <= 4'h0;
      first_ff     <= 1'b0;
      data_seen_ff <= 1'b0;
      rst_armed_ff <= 1'b0;
      id_sel_ff    <= 1'b0;
      id_idx_ff    <= 2'h0;
      sda_oe_ff    <= 1'b0;
    end else if (start_det) begin
      // new address phase; identity selection survives a repeated start only
      state_ff     <= ST_RX;
      cnt_ff       <= 4'h0;
      first_ff     <= 1'b1;
      data_seen_ff <= 1'b0;
      rst_armed_ff <= 1'b0;
      sda_oe_ff    <= 1'b0;
    end else if (stop_det) begin
      // stop ends everything; an armed reset lands here as well
      state_ff     <= ST_IDLE;
      ctx_ff       <= CTX_NONE;
      rst_armed_ff <= 1'b0;
      id_sel_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise && cnt_ff != i2cid_pkg::BYTE_BITS) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            cnt_ff   <= cnt_ff + 4'h1;
          end
          if (byte_done) begin
            first_ff <= 1'b0;
            if (first_ff && nxt_ctx != CTX_IDR) begin
              id_sel_ff <= 1'b0;
            end
            if (!first_ff) begin
              data_seen_ff <= 1'b1;
            end
            if (!first_ff && ctx_ff == CTX_GC) begin
              rst_armed_ff <= ack_c;
            end
            if (!first_ff && ctx_ff == CTX_IDW) begin
              id_sel_ff <= ack_c;
            end
            if (first_ff) begin
              id_idx_ff <= 2'h0;
            end
            ctx_ff    <= nxt_ctx;
            sda_oe_ff <= ack_c;
            // a refused byte leaves the slave deaf until the next start
            state_ff  <= ack_c ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (ctx_ff == CTX_IDR || ctx_ff == CTX_RD) begin
              sda_oe_ff <= ~tx_byte[7];
              shift_ff  <= {tx_byte[6:0], 1'b0};
              cnt_ff    <= 4'h1;
              state_ff  <= ST_TX;
            end else begin
              sda_oe_ff <= 1'b0;
              cnt_ff    <= 4'h0;
              state_ff  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == i2cid_pkg::BYTE_BITS) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= ST_TXACK;
            end else begin
              sda_oe_ff <= ~shift_ff[7];
              shift_ff  <= {shift_ff[6:0], 1'b0};
              cnt_ff    <= cnt_ff + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              state_ff  <= ST_IDLE;
              ctx_ff    <= CTX_NONE;
              id_sel_ff <= 1'b0;
            end else begin
              state_ff  <= ST_ACK;
              id_idx_ff <= (id_idx_ff == i2cid_pkg::ID_LAST_IDX) ? 2'h0 : id_idx_ff + 2'h1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // port register: written by data bytes of a write to own address, restored by any reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_ff <= i2cid_pkg::PORT_RESET;
    end else if (swrst_c) begin
      port_ff <= i2cid_pkg::PORT_RESET;
    end else if (byte_done && !first_ff && ctx_ff == CTX_WR) begin
      port_ff <= shift_ff;
    end
  end

  // one-cycle marker of a software reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      swrst_ff <= 1'b0;
    end else begin
      swrst_ff <= swrst_c;
    end
  end

  assign bus.dev_sda_oe = sda_oe_ff;
  assign port_o         = port_ff;
  assign own_addr_o     = own_addr_ff;
  assign swrst_o        = swrst_ff;
endmodule
`default_nettype wire

//--- design/i2cid_host.sv
`timescale 1ns/1ps
`default_nettype none
module i2cid_host #(
  parameter int QTR_CYC = i2cid_pkg::SCL_QTR_CYC  // system cycles per quarter bit
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  i2cid_bus_if.host       bus,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o
);
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_STOP, HS_BYTE} i2cid_hst_t;

  i2cid_hst_t  state_ff;     // current bus operation
  logic [1:0]  sda_sync_ff;  // data line synchroniser
  logic [15:0] div_ff;       // quarter-bit divider
  logic [1:0]  qtr_ff;       // quarter within a bit
  logic [3:0]  bit_ff;       // bit within a byte, ack is the ninth
  logic [7:0]  tx_ff;        // byte to send
  logic [7:0]  txsh_ff;      // send shifter
  logic [7:0]  rx_ff;        // last byte received
  logic [7:0]  rxsh_ff;      // receive shifter
  logic        rd_mode_ff;   // byte is a read
  logic        nack_ff;      // answer a read with no acknowledge
  logic        ack_ff;       // last acknowledge seen or given
  logic        scl_oe_ff;    // pulls clock low
  logic        sda_oe_ff;    // pulls data low
  logic [7:0]  rdata_ff;     // read data, one cycle after strobe
  logic        tick;         // quarter boundary
  logic        cmd_wr;

  assign tick   = (state_ff != HS_IDLE) && (div_ff == 16'(QTR_CYC - 1));
  // commands written while busy are dropped; software polls busy first
  assign cmd_wr = reg_wr_i && (reg_addr_i == i2cid_pkg::REG_CMD) && (state_ff == HS_IDLE);

  // data line passes two flops before sampling
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], bus.sda};
    end
  end

  // divider runs only during an operation
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= 16'h0000;
    end else if (state_ff == HS_IDLE || tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // transmit data register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_ff <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == i2cid_pkg::REG_TXD) begin
      tx_ff <= reg_wdata_i;
    end
  end

  // register reads answer in the next cycle; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        i2cid_pkg::REG_TXD:  rdata_ff <= tx_ff;
        i2cid_pkg::REG_STAT: rdata_ff <= {6'h00, ack_ff, state_ff != HS_IDLE};
        i2cid_pkg::REG_RXD:  rdata_ff <= rx_ff;
        default:             rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // bus sequencer: every bit is four quarters, clock low in the first two
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff   <= HS_IDLE;
      qtr_ff     <= 2'h0;
      bit_ff     <= 4'h0;
      txsh_ff    <= 8'h00;
      rxsh_ff    <= 8'h00;
      rx_ff      <= 8'h00;
      rd_mode_ff <= 1'b0;
      nack_ff    <= 1'b0;
      ack_ff     <= 1'b0;
      scl_oe_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else if (cmd_wr) begin
      qtr_ff     <= 2'h0;
      bit_ff     <= 4'h0;
      txsh_ff    <= tx_ff;
      rd_mode_ff <= reg_wdata_i[i2cid_pkg::CMD_READ_BIT] & ~reg_wdata_i[i2cid_pkg::CMD_WRITE_BIT];
      nack_ff    <= reg_wdata_i[i2cid_pkg::CMD_NACK_BIT];
      if (reg_wdata_i[i2cid_pkg::CMD_START_BIT]) begin
        state_ff <= HS_START;
      end else if (reg_wdata_i[i2cid_pkg::CMD_STOP_BIT]) begin
        state_ff <= HS_STOP;
      end else if (reg_wdata_i[i2cid_pkg::CMD_WRITE_BIT] | reg_wdata_i[i2cid_pkg::CMD_READ_BIT]) begin
        state_ff <= HS_BYTE;
      end
    end else if (tick) begin
      qtr_ff <= qtr_ff + 2'h1;
      case (state_ff)
        HS_START: begin
          // release data, raise clock, pull data, pull clock: also a repeated start
          case (qtr_ff)
            2'h0:    sda_oe_ff <= 1'b0;
            2'h1:    scl_oe_ff <= 1'b0;
            2'h2:    sda_oe_ff <= 1'b1;
            default: begin
              scl_oe_ff <= 1'b1;
              state_ff  <= HS_IDLE;
            end
          endcase
        end
        HS_STOP: begin
          case (qtr_ff)
            2'h0:    sda_oe_ff <= 1'b1;
            2'h1:    scl_oe_ff <= 1'b0;
            2'h2:    sda_oe_ff <= 1'b0;
            default: state_ff  <= HS_IDLE;
          endcase
        end
        HS_BYTE: begin
          case (qtr_ff)
            2'h0: begin
              if (bit_ff == i2cid_pkg::BYTE_BITS) begin
                sda_oe_ff <= rd_mode_ff & ~nack_ff;
              end else begin
                sda_oe_ff <= ~rd_mode_ff & ~txsh_ff[7];
              end
            end
            2'h1: scl_oe_ff <= 1'b0;
            2'h2: begin
              if (bit_ff == i2cid_pkg::BYTE_BITS) begin
                ack_ff <= ~sda_sync_ff[1];
              end else begin
                rxsh_ff <= {rxsh_ff[6:0], sda_sync_ff[1]};
              end
            end
            default: begin
              scl_oe_ff <= 1'b1;
              txsh_ff   <= {txsh_ff[6:0], 1'b0};
              bit_ff    <= bit_ff + 4'h1;
              if (bit_ff == i2cid_pkg::BYTE_BITS) begin
                sda_oe_ff <= 1'b0;
                rx_ff     <= rxsh_ff;
                state_ff  <= HS_IDLE;
              end
            end
          endcase
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  assign bus.host_scl_oe = scl_oe_ff;
  assign bus.host_sda_oe = sda_oe_ff;
  assign reg_rdata_o     = rdata_ff;
endmodule
`default_nettype wire

//--- design/i2cid_pkg.sv
package i2cid_pkg;
  // reserved and special bus addresses
  localparam logic [6:0] GC_ADDR     = 7'h00;  // general call, write form only
  localparam logic [6:0] ID_ADDR     = 7'h7c;  // reserved identity address 1111 100
  localparam logic [7:0] SWRST_BYTE  = 8'h06;  // software reset command byte
  localparam logic [7:0] PORT_RESET  = 8'hff;  // all lines input with weak pull-up
  // address map bases, chosen by which of the upper two straps sit on a bus line
  localparam logic [6:0] MAP_BASE_SS = 7'h20;  // upper static, middle static
  localparam logic [6:0] MAP_BASE_SB = 7'h10;  // upper static, middle on bus
  localparam logic [6:0] MAP_BASE_BB = 7'h50;  // upper on bus, middle on bus
  localparam logic [6:0] MAP_BASE_BS = 7'h60;  // upper on bus, middle static
  localparam logic [6:0] MAP_LO_STEP = 7'h08;  // lowest strap on a bus line
  localparam logic [6:0] MAP_LO_WIDE = 7'h10;  // same, when only the upper is on bus
  // sensed state of one strap pin; bit 0 is the address bit it contributes
  typedef enum logic [1:0] {
    STRAP_LOW  = 2'h0,
    STRAP_HIGH = 2'h1,
    STRAP_SCL  = 2'h2,
    STRAP_SDA  = 2'h3
  } i2cid_strap_t;
  // identity word layout
  localparam int MAKER_W  = 12;
  localparam int PART_W   = 9;
  localparam int REV_W    = 3;
  localparam int ID_W     = MAKER_W + PART_W + REV_W;
  localparam logic [1:0] ID_LAST_IDX = 2'h2;   // third identity byte
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  // controller register map
  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_TXD  = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_RXD  = 4'hc;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_WRITE_BIT = 2;
  localparam int CMD_READ_BIT  = 3;
  localparam int CMD_NACK_BIT  = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT  = 1;
  // bus clock timing
  localparam int SYS_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 1000;
  localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
endpackage

//--- tb/i2c_swreset_id_addr_decode_bench.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_swreset_id_addr_decode_bench;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i   = 1'b0;  // held low for 20 cycles
  logic [3:0] ra = 4'h0;         // register port, driven after edges
  logic [7:0] wd = 8'h00;
  logic       wr_s = 1'b0, rd_s = 1'b0;
  logic [7:0] rdata, port, s;    // s: last status or read byte
  logic [6:0] own;
  logic       swrst;
  int mismatches = 0, samples_checked = 0, cycles = 0, n_rst = 0;
  localparam logic [23:0] ID = {12'h5a3, 9'h0c6, 3'h1};  // arbitrary value
  always #2.5 clk_sys_i = ~clk_sys_i;
  i2cid_bus_if bus ();
  // straps clock, data, clock: expected address 5ah
  i2cid_dev #(.MAKER_ID(ID[23:12]), .PART_ID(ID[11:3]), .REV_ID(ID[2:0])) u_i2cid_dev (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus(bus), .addr_strap_hi_i(bus.scl),
    .addr_strap_mid_i(bus.sda), .addr_strap_lo_i(bus.scl), .port_o(port),
    .own_addr_o(own), .swrst_o(swrst));
  // short quarter keeps the run brief
  i2cid_host #(.QTR_CYC(6)) u_i2cid_host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .bus(bus), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_rdata_o(rdata));
  i2cid_checker u_i2cid_checker (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .scl(bus.scl),
    .sda(bus.sda), .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe));
  // count software reset pulses and cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (swrst === 1'b1) n_rst++;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) {ra, wd, wr_s} <= {a, d, 1'b1};
    @(posedge clk_sys_i) wr_s <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i) {ra, rd_s} <= {a, 1'b1};
    @(posedge clk_sys_i) rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // issue a command, then poll busy with a bound
  task automatic op(input logic [7:0] c);
    int n;
    wr(4'h0, c);
    s = 8'h01;
    for (n = 0; n < 400 && s[0] !== 1'b0; n++) rd(4'h8, s);
    // a controller stuck busy ends the run as a failure
    if (s[0] !== 1'b0) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic ack);
    wr(4'h4, d);
    op(8'h04);
    chk({7'h0, s[1]}, {7'h0, ack});
  endtask
  task automatic rb(input logic nk, input logic [7:0] exp);
    op(nk ? 8'h18 : 8'h08);
    rd(4'hc, s);
    chk(s, exp);
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1 chk(port, 8'hff);
    op(8'h01); op(8'h02); repeat (8) @(posedge clk_sys_i);
    chk({1'b0, own}, 8'h5a);
    rd(4'h2, s); chk(s, 8'h00);
    op(8'h01); wb(8'hb4, 1'b1); wb(8'h55, 1'b1); op(8'h02); chk(port, 8'h55);
    op(8'h01); wb(8'hb5, 1'b1); rb(1'b1, 8'h55); op(8'h02);
    op(8'h01); wb(8'h01, 1'b0); op(8'h02);
    op(8'h01); wb(8'h00, 1'b1); wb(8'h07, 1'b0); op(8'h02);
    chk(port, 8'h55);
    op(8'h01); wb(8'h00, 1'b1); wb(8'h06, 1'b1); wb(8'h06, 1'b0);
    op(8'h01); op(8'h02); chk(port, 8'h55);
    op(8'h01); wb(8'h00, 1'b1); wb(8'h06, 1'b1); op(8'h01); op(8'h02);
    chk(port, 8'h55); chk(n_rst[7:0], 8'h00);
    op(8'h01); wb(8'h00, 1'b1); wb(8'h06, 1'b1); op(8'h02);
    repeat (8) @(posedge clk_sys_i);
    chk(port, 8'hff); chk(n_rst[7:0], 8'h01);
    $display("test software reset done");
    op(8'h01); wb(8'hf8, 1'b1); wb(8'hb4, 1'b1); op(8'h01); wb(8'hf9, 1'b1);
    rb(1'b0, ID[23:16]); rb(1'b0, ID[15:8]); rb(1'b0, ID[7:0]);
    rb(1'b0, ID[23:16]); rb(1'b1, ID[15:8]); op(8'h02);
    op(8'h01); wb(8'hf8, 1'b1); wb(8'hb6, 1'b0); op(8'h02);
    op(8'h01); wb(8'hf8, 1'b1); wb(8'hb4, 1'b1); op(8'h02);
    op(8'h01); wb(8'hf9, 1'b0); op(8'h02);
    op(8'h01); wb(8'hf8, 1'b1); wb(8'hb4, 1'b1); op(8'h01); wb(8'h42, 1'b0);
    op(8'h01); wb(8'hf9, 1'b0); op(8'h02);
    $display("test identity read done");
    finish_test();
  end
endmodule
`default_nettype wire

//--- tb/i2cid_checker.sv
`timescale 1ns/1ps
`default_nettype none
module i2cid_checker (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  logic       scl_d_ff, sda_d_ff; // line levels one cycle back
  logic [3:0] bit_ff;             // clock rises in this byte
  logic [2:0] byte_ff;            // bytes since start, saturating
  logic [7:0] sh_ff;              // byte sampled so far
  logic       gc_ff, rd_ff;       // general call acked, read transfer
  wire start_w = scl & scl_d_ff & sda_d_ff & ~sda;
  wire rise_w  = scl & ~scl_d_ff;
  wire ack_w   = rise_w & (bit_ff == 4'h8);
  // delayed lines for edge finding
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) {scl_d_ff, sda_d_ff} <= 2'h3;
    else {scl_d_ff, sda_d_ff} <= {scl, sda};
  end
  // byte framing; start restarts it, repeated start too
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) {bit_ff, byte_ff, sh_ff} <= '0;
    else if (start_w) {bit_ff, byte_ff} <= '0;
    else if (ack_w) {bit_ff, byte_ff} <= {4'h0, byte_ff + {2'h0, ~&byte_ff}};
    else if (rise_w) {bit_ff, sh_ff} <= {bit_ff + 4'h1, sh_ff[6:0], sda};
  end
  // what the acked first byte opened
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) {gc_ff, rd_ff} <= 2'h0;
    else if (start_w) {gc_ff, rd_ff} <= 2'h0;
    else if (ack_w && byte_ff == 3'h0) {gc_ff, rd_ff} <= {sh_ff == 8'h00, sh_ff[0]} & {2{~sda}};
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence first_byte(logic [7:0] v);
    ack_w && byte_ff == 3'h0 && sh_ff == v;
  endsequence
  sequence gc_data;
    ack_w && gc_ff && byte_ff == 3'h1;
  endsequence
  a_dev_hold_high: assert property (scl && scl_d_ff |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  a_write_no_drive: assert property (rise_w && bit_ff != 4'h8 && !rd_ff |-> !dev_sda_oe)
    else $error("device drove a data bit of a write");
  a_gc_write_ack: assert property (first_byte(8'h00) |-> !sda)
    else $error("general call write not acknowledged");
  a_gc_read_nack: assert property (first_byte(8'h01) |-> sda)
    else $error("general call read acknowledged");
  a_id_addr_ack: assert property (first_byte(8'hf8) |-> !sda)
    else $error("identity address not acknowledged");
  a_rst_byte_ack: assert property (gc_data and sh_ff == 8'h06 |-> !sda)
    else $error("reset byte not acknowledged");
  a_rst_byte_nack: assert property (gc_data and sh_ff != 8'h06 |-> sda)
    else $error("wrong reset byte acknowledged");
  a_gc_extra_nack: assert property (ack_w && gc_ff && byte_ff > 3'h1 |-> sda)
    else $error("extra general call byte acknowledged");
endmodule
`default_nettype wire
